// File: logic/sdab_pkg.sv
// Constants, commands and timing shared by both ends of the SDRAM link
package sdab_pkg;
    localparam int CLK_MHZ = 20;
    localparam int CLK_PS = 1000000 / CLK_MHZ;

    localparam int ROW_W = 12;
    localparam int COL_W = 8;
    localparam int BA_W = 2;
    localparam int DQ_W = 32;
    localparam int NBANK = 4;
    localparam int CNT_W = 4;
    localparam int AP_BIT = 10;

    typedef logic [ROW_W-1:0] sdab_row_t;
    typedef logic [COL_W-1:0] sdab_col_t;
    typedef logic [BA_W-1:0] sdab_ba_t;
    typedef logic [DQ_W-1:0] sdab_data_t;
    typedef logic [NBANK-1:0] sdab_bmask_t;
    typedef logic [CNT_W-1:0] sdab_cnt_t;

    // Command code is {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_LMR = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_BST = 4'h6,
        CMD_NOP = 4'h7
    } sdab_cmd_e;

    // Mode word fields
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_PAGE = 3'h7;
    localparam sdab_col_t MASK_1 = 8'h00;
    localparam sdab_col_t MASK_2 = 8'h01;
    localparam sdab_col_t MASK_4 = 8'h03;
    localparam sdab_col_t MASK_8 = 8'h07;
    localparam sdab_col_t MASK_PAGE = 8'hff;
    localparam sdab_row_t MODE_RST = 12'h000;
    // Single-location writes, latency 2, sequential, burst of 4
    localparam sdab_row_t CTL_MODE = 12'h222;
    localparam int CAS_LAT = 2;
    localparam int CTL_BL = 4;

    localparam int T_RCD_NS = 20;
    localparam int T_RP_NS = 20;
    localparam int T_RC_NS = 60;
    localparam int T_RRD_NS = 15;

    // Least time in ns to whole clocks, rounded up, at least one
    function automatic int to_cyc(input int t_ns);
        int c;
        c = (t_ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : to_cyc

    localparam sdab_cnt_t RCD_LD = sdab_cnt_t'(to_cyc(T_RCD_NS) - 1);
    localparam sdab_cnt_t RP_LD = sdab_cnt_t'(to_cyc(T_RP_NS) - 1);
    localparam sdab_cnt_t RC_LD = sdab_cnt_t'(to_cyc(T_RC_NS) - 1);
    localparam sdab_cnt_t RRD_LD = sdab_cnt_t'(to_cyc(T_RRD_NS) - 1);
    // Beat counts at which read data stands on the pins
    localparam sdab_cnt_t RD_FIRST = sdab_cnt_t'(CAS_LAT);
    localparam sdab_cnt_t RD_LAST = sdab_cnt_t'(CAS_LAT + CTL_BL - 1);

    function automatic sdab_bmask_t bank_oh(input sdab_ba_t ba);
        bank_oh = '0;
        bank_oh[ba] = 1'b1;
    endfunction : bank_oh

    function automatic sdab_cnt_t dec(input sdab_cnt_t c);
        return (c == '0) ? c : sdab_cnt_t'(c - 1'b1);
    endfunction : dec
endpackage : sdab_pkg

// File: logic/sdab_if.sv
// Pin bundle between the SDRAM controller and the memory
`timescale 1ns/1ps
interface sdab_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    sdab_pkg::sdab_ba_t ba;
    sdab_pkg::sdab_row_t addr;
    logic dqm;
    sdab_pkg::sdab_data_t ctl_dq;
    logic ctl_dq_oe;
    sdab_pkg::sdab_data_t mem_dq;
    logic mem_dq_oe;

    modport ctl (
        output cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe,
        input mem_dq, mem_dq_oe
    );
    modport mem (
        input cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq, ctl_dq_oe,
        output mem_dq, mem_dq_oe
    );
endinterface : sdab_if

// File: logic/sdab_mem.sv
// Memory end: bank rows, read bursts with latency, output masking
`timescale 1ns/1ps
module sdab_mem (
    input wire logic i_clk,
    input wire logic i_srst,
    sdab_if.mem bus,
    output logic [sdab_pkg::NBANK-1:0] o_bank_open,
    output logic o_cmd_err,
    output logic o_wr_invalid
);
    localparam int CL = sdab_pkg::CAS_LAT;

    function automatic sdab_pkg::sdab_col_t blk_mask(input logic [2:0] bl);
        case (bl)
            sdab_pkg::BL_1: blk_mask = sdab_pkg::MASK_1;
            sdab_pkg::BL_2: blk_mask = sdab_pkg::MASK_2;
            sdab_pkg::BL_4: blk_mask = sdab_pkg::MASK_4;
            sdab_pkg::BL_8: blk_mask = sdab_pkg::MASK_8;
            default: blk_mask = sdab_pkg::MASK_PAGE;
        endcase
    endfunction : blk_mask

    // Column of burst element k inside the block chosen by mask
    function automatic sdab_pkg::sdab_col_t elem(
        input sdab_pkg::sdab_col_t start,
        input sdab_pkg::sdab_col_t k,
        input sdab_pkg::sdab_col_t mask,
        input logic ilv
    );
        sdab_pkg::sdab_col_t off;
        off = ilv ? (start ^ k) : sdab_pkg::sdab_col_t'(start + k);
        return (start & ~mask) | (off & mask);
    endfunction : elem

    sdab_pkg::sdab_data_t mem [0:(1 << (sdab_pkg::BA_W + sdab_pkg::COL_W))-1];
    sdab_pkg::sdab_row_t mode_reg;
    sdab_pkg::sdab_bmask_t open_reg;
    sdab_pkg::sdab_row_t row_reg [sdab_pkg::NBANK];
    logic bst_on_reg;
    logic bst_ap_reg;
    sdab_pkg::sdab_ba_t bst_bank_reg;
    sdab_pkg::sdab_col_t bst_start_reg;
    sdab_pkg::sdab_col_t bst_k_reg;
    logic close_reg;
    sdab_pkg::sdab_ba_t close_bank_reg;
    logic dqm_reg;
    logic [CL-2:0] pv_reg;
    sdab_pkg::sdab_data_t pd_reg [CL-1];
    logic oe_reg;
    sdab_pkg::sdab_data_t dq_reg;
    logic err_reg;
    logic wr_bad_reg;

    wire logic [3:0] cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    wire logic is_act = cmd == sdab_pkg::CMD_ACT;
    wire logic is_rd = cmd == sdab_pkg::CMD_RD;
    wire logic is_wr = cmd == sdab_pkg::CMD_WR;
    wire logic is_bst = cmd == sdab_pkg::CMD_BST;
    wire logic is_pre = cmd == sdab_pkg::CMD_PRE;
    wire logic is_lmr = cmd == sdab_pkg::CMD_LMR;
    wire logic a10 = bus.addr[sdab_pkg::AP_BIT];
    wire sdab_pkg::sdab_col_t col_in = bus.addr[sdab_pkg::COL_W-1:0];
    wire logic ba_open = open_reg[bus.ba];
    wire logic [2:0] bl = mode_reg[sdab_pkg::MR_BL_LSB +: 3];
    wire logic page = bl == sdab_pkg::BL_PAGE;
    wire logic ilv = mode_reg[sdab_pkg::MR_BT_BIT] & ~page;
    wire sdab_pkg::sdab_col_t mask = blk_mask(bl);

    // Burst stop: new READ, WRITE, terminate, or precharge of its bank
    wire logic pre_hit = is_pre & (a10 | bus.ba == bst_bank_reg);
    wire logic stop = is_rd | is_wr | is_bst | pre_hit;
    wire logic rd_ok = is_rd & ba_open;
    wire logic cont = bst_on_reg & ~stop;
    wire logic feed_v = rd_ok | cont;
    wire sdab_pkg::sdab_ba_t feed_bank = rd_ok ? bus.ba : bst_bank_reg;
    wire sdab_pkg::sdab_col_t feed_k = rd_ok ? '0 : bst_k_reg;
    wire sdab_pkg::sdab_col_t feed_start = rd_ok ? col_in : bst_start_reg;
    wire sdab_pkg::sdab_col_t feed_col =
        elem(feed_start, feed_k, mask, ilv);
    wire logic feed_last = ~page & (feed_k == mask);
    wire logic feed_ap = rd_ok ? (a10 & ~page) : bst_ap_reg;

    // Auto precharge closes at the slot an explicit PRECHARGE would
    wire logic intr_close = bst_on_reg & bst_ap_reg & stop;
    wire logic close_v = intr_close | (feed_v & feed_last & feed_ap);
    wire sdab_pkg::sdab_ba_t close_bank =
        intr_close ? bst_bank_reg : feed_bank;

    wire sdab_pkg::sdab_bmask_t act_oh =
        is_act ? sdab_pkg::bank_oh(bus.ba) : '0;
    wire sdab_pkg::sdab_bmask_t pre_oh =
        is_pre ? (a10 ? '1 : sdab_pkg::bank_oh(bus.ba)) : '0;
    wire sdab_pkg::sdab_bmask_t close_oh =
        close_reg ? sdab_pkg::bank_oh(close_bank_reg) : '0;
    wire sdab_pkg::sdab_bmask_t open_next =
        (open_reg & ~pre_oh & ~close_oh) | act_oh;

    // A WRITE over pending read data needs DQM high one clock before it
    wire logic rd_pending = bst_on_reg | (|pv_reg) | oe_reg;
    wire logic wr_bad = is_wr & rd_pending & ~dqm_reg;
    wire logic wr_ok = is_wr & ba_open & ~bus.dqm & ~wr_bad;
    wire logic err_next = ((is_rd | is_wr) & ~ba_open)
        | (is_act & ba_open);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_reg <= sdab_pkg::MODE_RST;
            open_reg <= '0;
            close_reg <= 1'b0;
            close_bank_reg <= '0;
            err_reg <= 1'b0;
            wr_bad_reg <= 1'b0;
            dqm_reg <= 1'b0;
        end else begin
            if (is_lmr) begin
                mode_reg <= bus.addr;
            end
            open_reg <= open_next;
            close_reg <= close_v;
            close_bank_reg <= close_bank;
            err_reg <= err_next;
            wr_bad_reg <= wr_bad;
            dqm_reg <= bus.dqm;
        end
    end

    always_ff @(posedge i_clk) begin
        for (int b = 0; b < sdab_pkg::NBANK; b++) begin
            if (act_oh[b]) begin
                row_reg[b] <= bus.addr;
            end
        end
        if (wr_ok) begin
            mem[{bus.ba, col_in}] <= bus.ctl_dq;
        end
    end

    // Burst address state
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bst_on_reg <= 1'b0;
            bst_ap_reg <= 1'b0;
            bst_bank_reg <= '0;
            bst_start_reg <= '0;
            bst_k_reg <= '0;
        end else begin
            bst_on_reg <= feed_v & ~feed_last;
            bst_ap_reg <= feed_ap;
            bst_bank_reg <= feed_bank;
            bst_start_reg <= feed_start;
            bst_k_reg <= sdab_pkg::sdab_col_t'(feed_k + 1'b1);
        end
    end

    // Latency pipe: stage 0 loads at the READ edge, pins at CL-1
    always_ff @(posedge i_clk) begin
        if (i_srst || is_wr) begin
            pv_reg <= '0;
            oe_reg <= 1'b0;
        end else begin
            pv_reg[0] <= feed_v;
            for (int i = 1; i < CL - 1; i++) begin
                pv_reg[i] <= pv_reg[i-1];
            end
            oe_reg <= pv_reg[CL-2] & ~dqm_reg;
        end
    end

    always_ff @(posedge i_clk) begin
        pd_reg[0] <= mem[{feed_bank, feed_col}];
        for (int i = 1; i < CL - 1; i++) begin
            pd_reg[i] <= pd_reg[i-1];
        end
        dq_reg <= pd_reg[CL-2];
    end

    assign bus.mem_dq = dq_reg;
    assign bus.mem_dq_oe = oe_reg;
    assign o_bank_open = open_reg;
    assign o_cmd_err = err_reg;
    assign o_wr_invalid = wr_bad_reg;
endmodule : sdab_mem

// File: logic/sdab_ctl.sv
// Controller end: opens rows, issues reads and writes with spacing
`timescale 1ns/1ps
module sdab_ctl (
    input wire logic i_clk,
    input wire logic i_srst,
    sdab_if.ctl bus,
    input wire logic i_req_valid,
    input wire logic i_req_wr,
    input wire sdab_pkg::sdab_ba_t i_req_bank,
    input wire sdab_pkg::sdab_row_t i_req_row,
    input wire sdab_pkg::sdab_col_t i_req_col,
    input wire sdab_pkg::sdab_data_t i_req_wdata,
    output logic o_req_ready,
    output logic o_rd_valid,
    output sdab_pkg::sdab_data_t o_rd_data
);
    typedef enum logic [2:0] {
        ST_MODE = 3'b000,
        ST_IDLE = 3'b001,
        ST_ACCESS = 3'b010,
        ST_RDATA = 3'b011,
        ST_TURN = 3'b100
    } sdab_st_e;

    sdab_st_e st_reg;
    sdab_st_e st_next;
    logic wr_reg;
    sdab_pkg::sdab_ba_t bank_reg;
    sdab_pkg::sdab_row_t rrow_reg;
    sdab_pkg::sdab_col_t col_reg;
    sdab_pkg::sdab_data_t wdata_reg;
    sdab_pkg::sdab_bmask_t open_reg;
    sdab_pkg::sdab_row_t row_reg [sdab_pkg::NBANK];
    sdab_pkg::sdab_cnt_t rcd_reg [sdab_pkg::NBANK];
    sdab_pkg::sdab_cnt_t rp_reg [sdab_pkg::NBANK];
    sdab_pkg::sdab_cnt_t rc_reg [sdab_pkg::NBANK];
    sdab_pkg::sdab_cnt_t rrd_reg;
    sdab_pkg::sdab_cnt_t beat_reg;
    logic [3:0] cmd_reg;
    logic [3:0] cmd_next;
    sdab_pkg::sdab_row_t addr_reg;
    sdab_pkg::sdab_row_t addr_next;
    sdab_pkg::sdab_ba_t ba_reg;
    sdab_pkg::sdab_data_t dq_reg;
    logic dq_oe_reg;
    logic dqm_reg;
    logic ready_reg;
    logic rv_reg;
    sdab_pkg::sdab_data_t rd_reg;

    wire logic take = (st_reg == ST_IDLE) & i_req_valid & ready_reg;
    wire logic b_open = open_reg[bank_reg];
    wire logic row_hit = row_reg[bank_reg] == rrow_reg;
    wire logic can_rw = b_open & row_hit & (rcd_reg[bank_reg] == '0);
    wire logic need_pre = b_open & ~row_hit;
    wire logic can_act = ~b_open & (rp_reg[bank_reg] == '0)
        & (rc_reg[bank_reg] == '0) & (rrd_reg == '0);
    wire logic in_access = st_reg == ST_ACCESS;
    wire logic act_go = in_access & ~b_open & can_act;
    wire logic pre_go = in_access & need_pre;
    wire logic rw_go = in_access & can_rw;
    wire logic cap = (st_reg == ST_RDATA) & (beat_reg >= sdab_pkg::RD_FIRST)
        & (beat_reg <= sdab_pkg::RD_LAST);
    wire sdab_pkg::sdab_bmask_t act_oh =
        act_go ? sdab_pkg::bank_oh(bank_reg) : '0;
    wire sdab_pkg::sdab_bmask_t pre_oh =
        pre_go ? sdab_pkg::bank_oh(bank_reg) : '0;

    always_comb begin
        st_next = st_reg;
        cmd_next = sdab_pkg::CMD_NOP;
        addr_next = rrow_reg;
        unique case (st_reg)
            ST_MODE: begin
                cmd_next = sdab_pkg::CMD_LMR;
                addr_next = sdab_pkg::CTL_MODE;
                st_next = ST_IDLE;
            end
            ST_IDLE: begin
                if (take) begin
                    st_next = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (rw_go) begin
                    cmd_next = wr_reg ? sdab_pkg::CMD_WR : sdab_pkg::CMD_RD;
                    addr_next = sdab_pkg::sdab_row_t'(col_reg);
                    st_next = wr_reg ? ST_TURN : ST_RDATA;
                end else if (pre_go) begin
                    cmd_next = sdab_pkg::CMD_PRE;
                    addr_next = '0;
                end else if (act_go) begin
                    cmd_next = sdab_pkg::CMD_ACT;
                end
            end
            ST_RDATA: begin
                if (beat_reg == sdab_pkg::RD_LAST) begin
                    st_next = ST_TURN;
                end
            end
            ST_TURN: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg <= ST_MODE;
            cmd_reg <= sdab_pkg::CMD_NOP;
            addr_reg <= '0;
            ba_reg <= '0;
            dq_oe_reg <= 1'b0;
            dqm_reg <= 1'b0;
            ready_reg <= 1'b0;
            rv_reg <= 1'b0;
            beat_reg <= '0;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            ba_reg <= bank_reg;
            dq_oe_reg <= rw_go & wr_reg;
            dqm_reg <= 1'b0;
            ready_reg <= st_next == ST_IDLE;
            rv_reg <= cap;
            beat_reg <= (st_reg == ST_RDATA)
                ? sdab_pkg::sdab_cnt_t'(beat_reg + 1'b1) : '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (take) begin
            wr_reg <= i_req_wr;
            bank_reg <= i_req_bank;
            rrow_reg <= i_req_row;
            col_reg <= i_req_col;
            wdata_reg <= i_req_wdata;
        end
        dq_reg <= wdata_reg;
        if (cap) begin
            rd_reg <= bus.mem_dq;
        end
    end

    // Per-bank state and spacing counters
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            open_reg <= '0;
            rrd_reg <= '0;
            for (int b = 0; b < sdab_pkg::NBANK; b++) begin
                rcd_reg[b] <= '0;
                rp_reg[b] <= '0;
                rc_reg[b] <= '0;
            end
        end else begin
            open_reg <= (open_reg & ~pre_oh) | act_oh;
            rrd_reg <= act_go ? sdab_pkg::RRD_LD : sdab_pkg::dec(rrd_reg);
            for (int b = 0; b < sdab_pkg::NBANK; b++) begin
                rcd_reg[b] <= act_oh[b] ? sdab_pkg::RCD_LD
                    : sdab_pkg::dec(rcd_reg[b]);
                rc_reg[b] <= act_oh[b] ? sdab_pkg::RC_LD
                    : sdab_pkg::dec(rc_reg[b]);
                rp_reg[b] <= pre_oh[b] ? sdab_pkg::RP_LD
                    : sdab_pkg::dec(rp_reg[b]);
                if (act_oh[b]) begin
                    row_reg[b] <= rrow_reg;
                end
            end
        end
    end

    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_reg;
    assign bus.ba = ba_reg;
    assign bus.addr = addr_reg;
    assign bus.dqm = dqm_reg;
    assign bus.ctl_dq = dq_reg;
    assign bus.ctl_dq_oe = dq_oe_reg;
    assign o_req_ready = ready_reg;
    assign o_rd_valid = rv_reg;
    assign o_rd_data = rd_reg;
endmodule : sdab_ctl

// File: dv/sdab_props.sv
// Pin-level checks between the controller and the memory
`timescale 1ns/1ps
module sdab_props (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire sdab_pkg::sdab_ba_t ba,
    input wire sdab_pkg::sdab_row_t addr,
    input wire logic dqm,
    input wire sdab_pkg::sdab_data_t ctl_dq,
    input wire logic ctl_dq_oe,
    input wire sdab_pkg::sdab_data_t mem_dq,
    input wire logic mem_dq_oe
);
    logic [3:0] cmd;
    logic is_act;
    logic is_rd;
    logic is_wr;
    logic is_pre;
    logic [3:0] sel;
    logic [3:0] open_reg;
    logic [3:0] open_next;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign is_act = (cmd == sdab_pkg::CMD_ACT);
    assign is_rd = (cmd == sdab_pkg::CMD_RD);
    assign is_wr = (cmd == sdab_pkg::CMD_WR);
    assign is_pre = (cmd == sdab_pkg::CMD_PRE);
    assign sel = 4'h1 << ba;
    // Open banks as seen from the command stream
    assign open_next = is_act ? (open_reg | sel) :
        (is_pre && addr[sdab_pkg::AP_BIT]) ? 4'h0 :
        is_pre ? (open_reg & ~sel) : open_reg;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            open_reg <= 4'h0;
        end else begin
            open_reg <= open_next;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    rd_open_bank_a: assert property ((is_rd || is_wr) |-> open_reg[ba])
        else $error("access to idle bank");
    act_idle_bank_a: assert property (is_act |-> !open_reg[ba])
        else $error("activate on open bank");
    rd_latency_a: assert property (is_rd |-> !mem_dq_oe ##1 !mem_dq_oe
        ##1 mem_dq_oe [*4] ##1 !mem_dq_oe)
        else $error("read burst timing wrong");
    oe_cause_a: assert property ($rose(mem_dq_oe) |-> $past(is_rd, 2))
        else $error("data driven without read");
    no_clash_a: assert property (!(ctl_dq_oe && mem_dq_oe))
        else $error("both ends drive data");
    wr_quiet_a: assert property (is_wr |->
        ctl_dq_oe && !mem_dq_oe && !dqm)
        else $error("write with bus busy or masked");
    act_to_col_a: assert property (is_act |-> ##[1:3] (is_rd || is_wr))
        else $error("no access after activate");
    pre_to_act_a: assert property (is_pre |-> ##[1:3] is_act)
        else $error("no activate after precharge");
    mode_load_a: assert property ($fell(i_srst) |->
        cmd == sdab_pkg::CMD_NOP
        ##1 (cmd == sdab_pkg::CMD_LMR && addr == sdab_pkg::CTL_MODE))
        else $error("mode load missing after reset");
    cover property (is_rd);
    cover property (is_wr);
    cover property (is_pre);
endmodule : sdab_props

// File: dv/tb_top.sv
// Bench: controller-memory pair plus a directly driven memory
`timescale 1ns/1ps
module tb_top;
    logic i_clk;
    logic i_srst;
    logic req_valid;
    logic req_wr;
    sdab_pkg::sdab_ba_t req_bank;
    sdab_pkg::sdab_row_t req_row;
    sdab_pkg::sdab_col_t req_col;
    sdab_pkg::sdab_data_t req_wdata;
    logic req_ready;
    logic rd_valid;
    sdab_pkg::sdab_data_t rd_data;
    logic err_a;
    logic err_b;
    logic inv_b;
    logic seen_err;
    logic [3:0] open_b;
    logic [31:0] model [1024];
    int err_total;
    int n_tests;
    int cyc;
    sdab_if bus_a ();
    sdab_if bus_b ();
    sdab_ctl sdab_ctl_inst (.i_clk(i_clk), .i_srst(i_srst), .bus(bus_a.ctl),
        .i_req_valid(req_valid), .i_req_wr(req_wr), .i_req_bank(req_bank),
        .i_req_row(req_row), .i_req_col(req_col), .i_req_wdata(req_wdata),
        .o_req_ready(req_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
    sdab_mem sdab_mem_inst (.i_clk(i_clk), .i_srst(i_srst), .bus(bus_a.mem),
        .o_bank_open(), .o_cmd_err(err_a), .o_wr_invalid());
    sdab_mem sdab_mem_inst_b (.i_clk(i_clk), .i_srst(i_srst),
        .bus(bus_b.mem), .o_bank_open(open_b), .o_cmd_err(err_b),
        .o_wr_invalid(inv_b));
    sdab_props sdab_props_inst (.i_clk(i_clk), .i_srst(i_srst),
        .cs_n(bus_a.cs_n), .ras_n(bus_a.ras_n), .cas_n(bus_a.cas_n),
        .we_n(bus_a.we_n), .ba(bus_a.ba), .addr(bus_a.addr),
        .dqm(bus_a.dqm), .ctl_dq(bus_a.ctl_dq), .ctl_dq_oe(bus_a.ctl_dq_oe),
        .mem_dq(bus_a.mem_dq), .mem_dq_oe(bus_a.mem_dq_oe));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    function automatic logic [31:0] wd(input logic [1:0] b,
        input logic [11:0] r, input logic [7:0] c);
        return {8'h9a, 2'h0, b, r, c};
    endfunction : wd

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic results;
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic req(input logic wr, input logic [1:0] b,
        input logic [11:0] r, input logic [7:0] c);
        int n;
        @(negedge i_clk);
        req_valid = 1'b1;
        req_wr = wr;
        req_bank = b;
        req_row = r;
        req_col = c;
        req_wdata = wd(b, r, c);
        n = 0;
        while (req_ready !== 1'b1 && n < 60) begin
            @(negedge i_clk);
            n++;
        end
        @(negedge i_clk);
        req_valid = 1'b0;
        if (wr) begin
            model[{b, c}] = wd(b, r, c);
        end
    endtask : req

    task automatic rd_a(input logic [1:0] b, input logic [11:0] r,
        input logic [7:0] c);
        int k;
        int n;
        req(1'b0, b, r, c);
        k = 0;
        for (n = 0; n < 30 && k < 4; n++) begin
            if (rd_valid === 1'b1) begin
                check("rd_data", model[{b, c[7:2], c[1:0] + 2'(k)}],
                    rd_data);
                k++;
            end
            @(negedge i_clk);
        end
        check("rd_beats", 32'h4, 32'(k));
    endtask : rd_a

    task automatic cmd_b(input logic [3:0] c, input logic [1:0] b,
        input logic [11:0] a);
        @(negedge i_clk);
        {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = c;
        bus_b.ba = b;
        bus_b.addr = a;
    endtask : cmd_b

    task automatic chk_b(input logic oe, input logic [7:0] c);
        check("mem_dq_oe", {31'h0, oe}, {31'h0, bus_b.mem_dq_oe});
        if (oe) begin
            check("mem_dq", wd(2'h1, 12'h005, c), bus_b.mem_dq);
        end
    endtask : chk_b

    task automatic nc(input logic oe, input logic [7:0] c);
        cmd_b(sdab_pkg::CMD_NOP, 2'h0, 12'h000);
        chk_b(oe, c);
    endtask : nc

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (err_a === 1'b1) begin
            seen_err <= 1'b1;
        end
        if (cyc == 3000) begin
            err_total++;
            results();
        end
    end

    initial begin
        int i;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        seen_err = 1'b0;
        i_srst = 1'b1;
        req_valid = 1'b0;
        req_wr = 1'b0;
        req_bank = '0;
        req_row = '0;
        req_col = '0;
        req_wdata = '0;
        {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = 4'h7;
        bus_b.ba = '0;
        bus_b.addr = '0;
        bus_b.dqm = 1'b0;
        bus_b.ctl_dq = '0;
        bus_b.ctl_dq_oe = 1'b0;
        repeat (5) @(posedge i_clk);
        @(negedge i_clk);
        i_srst = 1'b0;
        for (i = 0; i < 8; i++) begin
            req(1'b1, (i < 4) ? 2'h0 : 2'h2, 12'h001, 8'(4 + i % 4));
        end
        rd_a(2'h0, 12'h001, 8'h05);
        rd_a(2'h2, 12'h001, 8'h07);
        req(1'b1, 2'h0, 12'h002, 8'h06);
        rd_a(2'h0, 12'h002, 8'h04);
        // Directly driven memory
        cmd_b(sdab_pkg::CMD_LMR, 2'h0, 12'h002);
        cmd_b(sdab_pkg::CMD_ACT, 2'h1, 12'h005);
        for (i = 0; i < 8; i++) begin
            cmd_b(sdab_pkg::CMD_WR, 2'h1, {4'h0, 8'(252 + i)});
            bus_b.ctl_dq = wd(2'h1, 12'h005, 8'(252 + i));
            bus_b.ctl_dq_oe = 1'b1;
        end
        nc(1'b0, 8'h00);
        bus_b.ctl_dq_oe = 1'b0;
        bus_b.ctl_dq = ~bus_b.ctl_dq;
        check("bank_open", 32'h2, {28'h0, open_b});
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h002);
        nc(1'b0, 8'h00);
        for (i = 0; i < 4; i++) begin
            nc(1'b1, {6'h0, 2'(2 + i)});
        end
        nc(1'b0, 8'h00);
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h002);
        nc(1'b0, 8'h00);
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h000);
        chk_b(1'b1, 8'h02);
        nc(1'b1, 8'h03);
        for (i = 0; i < 4; i++) begin
            nc(1'b1, 8'(i));
        end
        nc(1'b0, 8'h00);
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h000);
        nc(1'b0, 8'h00);
        cmd_b(sdab_pkg::CMD_BST, 2'h1, 12'h000);
        chk_b(1'b1, 8'h00);
        nc(1'b1, 8'h01);
        nc(1'b0, 8'h00);
        cmd_b(sdab_pkg::CMD_LMR, 2'h0, 12'h007);
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h0fe);
        nc(1'b0, 8'h00);
        for (i = 0; i < 4; i++) begin
            nc(1'b1, 8'(254 + i));
        end
        cmd_b(sdab_pkg::CMD_BST, 2'h1, 12'h000);
        chk_b(1'b1, 8'h02);
        nc(1'b1, 8'h03);
        nc(1'b0, 8'h00);
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h000);
        nc(1'b0, 8'h00);
        bus_b.dqm = 1'b1;
        nc(1'b1, 8'h00);
        bus_b.dqm = 1'b0;
        nc(1'b0, 8'h00);
        nc(1'b1, 8'h02);
        cmd_b(sdab_pkg::CMD_WR, 2'h1, 12'h003);
        bus_b.ctl_dq = 32'h0;
        bus_b.ctl_dq_oe = 1'b1;
        nc(1'b0, 8'h00);
        bus_b.ctl_dq_oe = 1'b0;
        bus_b.ctl_dq = ~bus_b.ctl_dq;
        check("wr_invalid", 32'h1, {31'h0, inv_b});
        cmd_b(sdab_pkg::CMD_LMR, 2'h0, 12'h002);
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h000);
        nc(1'b0, 8'h00);
        cmd_b(sdab_pkg::CMD_PRE, 2'h1, 12'h000);
        chk_b(1'b1, 8'h00);
        nc(1'b1, 8'h01);
        nc(1'b0, 8'h00);
        check("bank_open", 32'h0, {28'h0, open_b});
        cmd_b(sdab_pkg::CMD_ACT, 2'h1, 12'h005);
        // Interleaved burst of four from column 1
        cmd_b(sdab_pkg::CMD_LMR, 2'h0, 12'h00a);
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h001);
        nc(1'b0, 8'h00);
        nc(1'b1, 8'h01);
        nc(1'b1, 8'h00);
        nc(1'b1, 8'h03);
        nc(1'b1, 8'h02);
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h401);
        for (i = 0; i < 8; i++) begin
            cmd_b(sdab_pkg::CMD_NOP, 2'h0, 12'h000);
        end
        check("bank_open", 32'h0, {28'h0, open_b});
        cmd_b(sdab_pkg::CMD_RD, 2'h1, 12'h000);
        cmd_b(sdab_pkg::CMD_NOP, 2'h0, 12'h000);
        check("cmd_err", 32'h1, {31'h0, err_b});
        cmd_b(sdab_pkg::CMD_ACT, 2'h0, 12'h00a);
        cmd_b(sdab_pkg::CMD_ACT, 2'h3, 12'h00b);
        cmd_b(sdab_pkg::CMD_NOP, 2'h0, 12'h000);
        check("bank_open", 32'h9, {28'h0, open_b});
        cmd_b(sdab_pkg::CMD_PRE, 2'h2, 12'h400);
        cmd_b(sdab_pkg::CMD_NOP, 2'h0, 12'h000);
        check("bank_open", 32'h0, {28'h0, open_b});
        check("ctl_cmd_err", 32'h0, {31'h0, seen_err});
        results();
    end
endmodule : tb_top
